// *** bench/ccm_pin_model.sv ***
`timescale 1ns/1ps
// =============================================================
// Far side: drives the two timer input pins
module ccm_pin_model (
    // Clock
    input  wire logic sys_clk,
    // Timer pins
    output logic      pin_a,
    output logic      pin_b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // Pulse one pin; idle low, wide pulse so the sync chain sees it
    task automatic pulse(input bit sel_b);
        @(posedge sys_clk);
        if (sel_b) pin_b <= 1'b1; else pin_a <= 1'b1;
        repeat (4) @(posedge sys_clk);
        if (sel_b) pin_b <= 1'b0; else pin_a <= 1'b0;
        repeat (5) @(posedge sys_clk); // Let both edges land
    endtask : pulse
endmodule : ccm_pin_model

// *** bench/ccm_timer_capcmp_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
// =============================================================
// Top bench
module ccm_timer_capcmp_tb_top;
    import ccm_pkg::*;
    logic        sys_clk = 1'b0, rst = 1'b1;
    logic [15:0] cpu_addr = '0, cpu_wdata = '0, cpu_rdata;
    logic [7:0]  cpu_wmask = '0;
    logic        cpu_wr = 1'b0, cpu_wide = 1'b0, cpu_rd = 1'b0;
    logic        count_tick = 1'b0;
    logic        pin_a, pin_b, pin_out, pri_irq, sec_irq;
    int          n_mismatch = 0, num_checks = 0, pri_n = 0, sec_n = 0;
    logic        p0;
    logic [1:0]  a_sel = CCM_EDGE_RISE, b_sel = CCM_EDGE_RISE;

    always #2 sys_clk = ~sys_clk;

    ccm_timer_capcmp u_ccm_timer_capcmp (
        .sys_clk(sys_clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wmask(cpu_wmask), .cpu_wr(cpu_wr), .cpu_wide(cpu_wide),
        .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .count_tick(count_tick),
        .input_a_edge_sel(a_sel), .input_b_edge_sel(b_sel),
        .timer_input_a(pin_a), .timer_input_b(pin_b),
        .timer_output_pin(pin_out), .primary_match_irq(pri_irq),
        .secondary_match_irq(sec_irq));
    ccm_pin_model u_ccm_pin_model (.sys_clk(sys_clk), .pin_a(pin_a), .pin_b(pin_b));

    // Irq pulses are one cycle wide, so count them at every edge
    always @(posedge sys_clk) begin
        if (pri_irq === 1'b1) pri_n++;
        if (sec_irq === 1'b1) sec_n++;
    end

    // =============================================================
    // Register port tasks
    task automatic wr(input logic [15:0] a, d, input logic [7:0] m, input logic w);
        @(posedge sys_clk);
        cpu_addr <= a; cpu_wdata <= d; cpu_wmask <= m; cpu_wide <= w; cpu_wr <= 1'b1;
        @(posedge sys_clk);
        cpu_wr <= 1'b0;
    endtask : wr

    task automatic ck(input string nm, input logic [15:0] a, e);
        @(posedge sys_clk);
        cpu_addr <= a; cpu_rd <= 1'b1;
        @(posedge sys_clk);
        cpu_rd <= 1'b0;
        #1 `CHK(nm, e, cpu_rdata)
    endtask : ck

    // Single count ticks, then one edge so irqs are counted
    task automatic tk(input int n);
        repeat (n) begin
            @(posedge sys_clk) count_tick <= 1'b1;
            @(posedge sys_clk) count_tick <= 1'b0;
        end
        @(posedge sys_clk);
        #1;
    endtask : tk

    // =============================================================
    // Scenarios
    task automatic t_reset;
        ck("mode", CCM_ADDR_MODE, 16'h0000);
        ck("role", CCM_ADDR_ROLE, 16'h0000);
        ck("pri", CCM_ADDR_PRI, 16'h0000);
        ck("sec", CCM_ADDR_SEC, 16'h0000);
        ck("count", CCM_ADDR_COUNT, 16'h0000);
        `CHK("pin", 1'b0, pin_out)
        $display("done: reset values");
    endtask : t_reset

    task automatic t_bus;
        wr(CCM_ADDR_PRI, 16'h1234, 8'hff, 1'b0);
        ck("pri narrow", CCM_ADDR_PRI, 16'h0000);
        wr(CCM_ADDR_MODE, 16'h00f0, 8'hff, 1'b0);
        ck("mode upper", CCM_ADDR_MODE, 16'h0000);
        ck("unmapped", 16'hff00, 16'h0000);
        $display("done: register port");
    endtask : t_bus

    task automatic t_compare;
        wr(CCM_ADDR_PRI, 16'h0002, 8'hff, 1'b1);
        wr(CCM_ADDR_SEC, 16'h0001, 8'hff, 1'b1);
        wr(CCM_ADDR_MODE, 16'h0004, 8'hff, 1'b0);
        pri_n = 0; sec_n = 0;
        tk(2);
        `CHK("sec irq", 1, sec_n)
        `CHK("pin 1", 1'b1, pin_out)
        `CHK("pri early", 0, pri_n)
        tk(1);
        `CHK("pri irq", 1, pri_n)
        `CHK("pin 2", 1'b0, pin_out)
        u_ccm_pin_model.pulse(1'b0);
        u_ccm_pin_model.pulse(1'b1);
        `CHK("pin a edge", 1'b0, pin_out)
        ck("pri held", CCM_ADDR_PRI, 16'h0002);
        ck("sec held", CCM_ADDR_SEC, 16'h0001);
        ck("count", CCM_ADDR_COUNT, 16'h0003);
        $display("done: compare matches");
    endtask : t_compare

    task automatic t_zero_wrap;
        wr(CCM_ADDR_MODE, 16'h0000, 8'hff, 1'b0);
        ck("stopped", CCM_ADDR_COUNT, 16'h0000);
        wr(CCM_ADDR_PRI, 16'h0000, 8'hff, 1'b1);
        wr(CCM_ADDR_SEC, 16'hffff, 8'hff, 1'b1);
        wr(CCM_ADDR_MODE, 16'h0004, 8'hff, 1'b0);
        pri_n = 0; sec_n = 0;
        tk(1);
        `CHK("no start irq", 0, pri_n)
        @(posedge sys_clk) count_tick <= 1'b1;
        repeat (65535) @(posedge sys_clk);
        count_tick <= 1'b0;
        tk(0);
        ck("wrap flag", CCM_ADDR_MODE, 16'h0005);
        `CHK("sec at top", 1, sec_n)
        `CHK("pri none", 0, pri_n)
        tk(1);
        `CHK("pri 0 to 1", 1, pri_n)
        wr(CCM_ADDR_MODE, 16'h0000, 8'hff, 1'b0);
        ck("stop clr", CCM_ADDR_MODE, 16'h0000);
        ck("count clr", CCM_ADDR_COUNT, 16'h0000);
        wr(CCM_ADDR_MODE, 16'h0001, 8'h01, 1'b0);
        ck("flag set", CCM_ADDR_MODE, 16'h0001);
        wr(CCM_ADDR_MODE, 16'h0000, 8'h01, 1'b0);
        ck("flag clr", CCM_ADDR_MODE, 16'h0000);
        $display("done: zero compare and wrap");
    endtask : t_zero_wrap

    task automatic t_capture;
        wr(CCM_ADDR_ROLE, 16'h0005, 8'hff, 1'b0);
        wr(CCM_ADDR_MODE, 16'h0006, 8'hff, 1'b0);
        tk(5);
        u_ccm_pin_model.pulse(1'b1);
        ck("pri cap b", CCM_ADDR_PRI, 16'h0005);
        ck("sec no b", CCM_ADDR_SEC, 16'hffff);
        tk(2);
        p0 = pin_out;
        u_ccm_pin_model.pulse(1'b0);
        ck("sec cap a", CCM_ADDR_SEC, 16'h0007);
        ck("pri no a", CCM_ADDR_PRI, 16'h0005);
        `CHK("pin a toggle", ~p0, pin_out)
        wr(CCM_ADDR_MODE, 16'h0000, 8'hff, 1'b0);
        wr(CCM_ADDR_ROLE, 16'h0007, 8'hff, 1'b0);
        wr(CCM_ADDR_MODE, 16'h0004, 8'hff, 1'b0);
        tk(3);
        pri_n = 0;
        u_ccm_pin_model.pulse(1'b0);
        ck("pri reverse", CCM_ADDR_PRI, 16'h0003);
        ck("sec indep", CCM_ADDR_SEC, 16'h0003);
        `CHK("no cap irq", 0, pri_n)
        tk(2);
        u_ccm_pin_model.pulse(1'b1);
        `CHK("ext irq", 1, pri_n)
        ck("pri kept", CCM_ADDR_PRI, 16'h0003);
        // Both edges: input A leaves no reverse edge, input B fires twice
        @(posedge sys_clk) a_sel <= CCM_EDGE_BOTH;
        b_sel <= CCM_EDGE_BOTH;
        tk(1);
        pri_n = 0;
        u_ccm_pin_model.pulse(1'b0);
        ck("pri no reverse", CCM_ADDR_PRI, 16'h0003);
        ck("sec both", CCM_ADDR_SEC, 16'h0006);
        u_ccm_pin_model.pulse(1'b1);
        `CHK("ext irq both", 2, pri_n)
        $display("done: capture");
    endtask : t_capture

    task automatic t_clear;
        wr(CCM_ADDR_MODE, 16'h0000, 8'hff, 1'b0);
        wr(CCM_ADDR_ROLE, 16'h0000, 8'hff, 1'b0);
        wr(CCM_ADDR_PRI, 16'h0003, 8'hff, 1'b1);
        wr(CCM_ADDR_MODE, 16'h000c, 8'hff, 1'b0);
        pri_n = 0;
        tk(5);
        `CHK("match clr irq", 1, pri_n)
        ck("match clr", CCM_ADDR_COUNT, 16'h0001);
        wr(CCM_ADDR_MODE, 16'h0000, 8'hff, 1'b0);
        wr(CCM_ADDR_MODE, 16'h0008, 8'hff, 1'b0);
        @(posedge sys_clk) a_sel <= CCM_EDGE_FALL;
        tk(3);
        u_ccm_pin_model.pulse(1'b0);
        ck("edge clr", CCM_ADDR_COUNT, 16'h0000);
        $display("done: clear modes");
    endtask : t_clear

    // =============================================================
    // Verdict
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_bus();
        t_compare();
        t_zero_wrap();
        t_capture();
        t_clear();
        give_verdict();
    end
endmodule : ccm_timer_capcmp_tb_top

// *** rtl/ccm_capcmp_unit.sv ***
`timescale 1ns/1ps
module ccm_capcmp_unit import ccm_pkg::*; (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Role and software write
    input  wire logic        role_capture,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    // Counter view
    input  wire logic [15:0] count,
    input  wire logic        running,
    input  wire logic        count_tick,
    input  wire logic        first_tick,
    input  wire logic        capture_trig,
    // Results
    output logic [15:0]      value,
    output logic             match
);
    typedef struct packed {
        logic [15:0] value;
    } ccm_cc_s;

    ccm_cc_s st_r;
    ccm_cc_s st_nxt;

    // Match on the tick leaving the equal count; first tick after start masked
    always_comb begin
        match = !role_capture && running && count_tick && !first_tick
                && (count == st_r.value);
    end

    // Software write beats a capture landing in the same cycle
    always_comb begin
        st_nxt = st_r;
        if (wr_en) begin
            st_nxt.value = wr_data;
        end else if (role_capture && running && capture_trig) begin
            st_nxt.value = count;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r.value <= CCM_CC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value = st_r.value;
endmodule : ccm_capcmp_unit

// *** rtl/ccm_edge_sync.sv ***
`timescale 1ns/1ps
module ccm_edge_sync import ccm_pkg::*; (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Pin and edge choice
    input  wire logic       pin_in,
    input  wire logic [1:0] edge_sel,
    // Edge events
    output logic            valid_edge,
    output logic            reverse_edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } ccm_sync_s;

    ccm_sync_s st_r;
    ccm_sync_s st_nxt;
    logic      rise;
    logic      fall;
    logic [1:0] rev_sel;

    // =========================================================================
    // Edge decode shared by valid and reverse paths
    function automatic logic ccm_edge_hit(input logic [1:0] sel, input logic r,
                                          input logic f);
        case (sel)
            CCM_EDGE_FALL: ccm_edge_hit = f;
            CCM_EDGE_RISE: ccm_edge_hit = r;
            CCM_EDGE_BOTH: ccm_edge_hit = r | f;
            default:       ccm_edge_hit = 1'b0;
        endcase
    endfunction : ccm_edge_hit

    // Meta flop feeds only the sync flop
    always_comb begin
        st_nxt.meta = pin_in;
        st_nxt.sync = st_r.meta;
        st_nxt.last = st_r.sync;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Both-edge choice leaves no reverse edge to detect
    always_comb begin
        rise = st_r.sync & ~st_r.last;
        fall = ~st_r.sync & st_r.last;
        case (edge_sel)
            CCM_EDGE_FALL: rev_sel = CCM_EDGE_RISE;
            CCM_EDGE_RISE: rev_sel = CCM_EDGE_FALL;
            default:       rev_sel = CCM_EDGE_NONE;
        endcase
        valid_edge   = ccm_edge_hit(edge_sel, rise, fall);
        reverse_edge = ccm_edge_hit(rev_sel, rise, fall);
    end
endmodule : ccm_edge_sync

// *** rtl/ccm_pkg.sv ***
// How it works
// - Both capture/compare registers are 16 bits, whole-word access, reset to 0000H.
// - Primary compare matches counter, raises primary match interrupt, value held.
// - A register in compare role ignores every capture trigger.
// - Primary capture latches counter on input A reverse edge when trigger select is 1, else on input B edge.
// - Secondary compare matches counter and raises secondary match interrupt.
// - Secondary capture latches counter on input A valid edge.
// - A zero compare gives no match at start; first match at 0000H to 0001H.
// - Secondary capture ignores the primary trigger select bit.
// - Reverse-edge capture gives no match irq; input B edge raises it instead.
// - Mode control takes bit and byte writes and resets to 00H.
// - Counting starts when run mode goes nonzero, stops on 00.
// - Run mode 00 stop and clear, 01 free, 10 edge clear, 11 match clear.
// - Output toggles on either match, plus input A edge when select is 1 and the timer is running.
// - Wrap flag sets on FFFFH to 0000H; cleared by writing 0 or stopping.
// - Writing 1 to the wrap flag sets it.
// - Counter steps on each count tick and reads 0000H while stopped.
// - Role select bit 0 means compare, 1 means capture.
package ccm_pkg;
    // =========================================================================
    // Register addresses
    localparam logic [15:0] CCM_ADDR_MODE  = 16'hffba;
    localparam logic [15:0] CCM_ADDR_ROLE  = 16'hffbc;
    localparam logic [15:0] CCM_ADDR_PRI   = 16'hffb0;
    localparam logic [15:0] CCM_ADDR_SEC   = 16'hffb2;
    localparam logic [15:0] CCM_ADDR_COUNT = 16'hffb4;

    // =========================================================================
    // Reset values and writable masks
    localparam logic [7:0]  CCM_MODE_RST   = 8'h00;
    localparam logic [7:0]  CCM_ROLE_RST   = 8'h00;
    localparam logic [15:0] CCM_CC_RST     = 16'h0000;
    localparam logic [7:0]  CCM_MODE_MASK  = 8'h0f;
    localparam logic [7:0]  CCM_ROLE_MASK  = 8'h07;

    // =========================================================================
    // Field positions
    localparam int unsigned CCM_WRAP_BIT     = 0;
    localparam int unsigned CCM_TOGGLE_BIT   = 1;
    localparam int unsigned CCM_RUN_LO_BIT   = 2;
    localparam int unsigned CCM_RUN_HI_BIT   = 3;
    localparam int unsigned CCM_PRI_ROLE_BIT = 0;
    localparam int unsigned CCM_PRI_TRIG_BIT = 1;
    localparam int unsigned CCM_SEC_ROLE_BIT = 2;

    // =========================================================================
    // Counter limits
    localparam logic [15:0] CCM_COUNT_ZERO = 16'h0000;
    localparam logic [15:0] CCM_COUNT_MAX  = 16'hffff;
    localparam logic [15:0] CCM_COUNT_ONE  = 16'h0001;

    // =========================================================================
    // Run modes and edge selections
    typedef enum logic [1:0] {
        CCM_STOP      = 2'b00,
        CCM_FREE      = 2'b01,
        CCM_EDGE_CLR  = 2'b10,
        CCM_MATCH_CLR = 2'b11
    } ccm_run_e;

    typedef enum logic [1:0] {
        CCM_EDGE_FALL = 2'b00,
        CCM_EDGE_RISE = 2'b01,
        CCM_EDGE_NONE = 2'b10,
        CCM_EDGE_BOTH = 2'b11
    } ccm_edge_e;
endpackage : ccm_pkg

// *** rtl/ccm_timer_capcmp.sv ***
`timescale 1ns/1ps
module ccm_timer_capcmp import ccm_pkg::*; (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // CPU register port
    input  wire logic [15:0] cpu_addr,
    input  wire logic [15:0] cpu_wdata,
    input  wire logic [7:0]  cpu_wmask,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_wide,
    input  wire logic        cpu_rd,
    output logic [15:0]      cpu_rdata,
    // Count clock enable and edge choices
    input  wire logic        count_tick,
    input  wire logic [1:0]  input_a_edge_sel,
    input  wire logic [1:0]  input_b_edge_sel,
    // Timer pins
    input  wire logic        timer_input_a,
    input  wire logic        timer_input_b,
    output logic             timer_output_pin,
    // Interrupt requests
    output logic             primary_match_irq,
    output logic             secondary_match_irq
);
    typedef struct packed {
        logic [7:0]  mode_control_reg;
        logic [7:0]  capture_role_control;
        logic [15:0] count_value;
        logic        first_tick;
        logic        pri_irq;
        logic        sec_irq;
        logic        tout;
        logic [15:0] rdata;
    } ccm_top_s;

    ccm_top_s    st_r;
    ccm_top_s    st_nxt;
    ccm_run_e    run_mode;
    logic        running;
    logic        a_valid;
    logic        a_reverse;
    logic        b_valid;
    logic        pri_match;
    logic        sec_match;
    logic        pri_trig;
    logic        ext_irq;
    logic        clear_evt;
    logic        wrap_set;
    logic        wr_mode;
    logic        wr_role;
    logic        wr_pri;
    logic        wr_sec;
    logic [7:0]  mode_new;
    logic [7:0]  role_new;
    logic [15:0] pri_value;
    logic [15:0] sec_value;
    logic        pri_role;
    logic        sec_role;
    logic        trig_sel;
    logic        toggle_sel;

    // =========================================================================
    // Input conditioning
    ccm_edge_sync u_sync_a (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .pin_in       (timer_input_a),
        .edge_sel     (input_a_edge_sel),
        .valid_edge   (a_valid),
        .reverse_edge (a_reverse)
    );

    ccm_edge_sync u_sync_b (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .pin_in       (timer_input_b),
        .edge_sel     (input_b_edge_sel),
        .valid_edge   (b_valid),
        .reverse_edge ()
    );

    // =========================================================================
    // Decode of control fields
    always_comb begin
        run_mode   = ccm_run_e'({st_r.mode_control_reg[CCM_RUN_HI_BIT],
                                 st_r.mode_control_reg[CCM_RUN_LO_BIT]});
        running    = (run_mode != CCM_STOP);
        toggle_sel = st_r.mode_control_reg[CCM_TOGGLE_BIT];
        pri_role   = st_r.capture_role_control[CCM_PRI_ROLE_BIT];
        trig_sel   = st_r.capture_role_control[CCM_PRI_TRIG_BIT];
        sec_role   = st_r.capture_role_control[CCM_SEC_ROLE_BIT];
    end

    // Byte-wide registers merge bit writes through the mask
    always_comb begin
        wr_mode  = cpu_wr && (cpu_addr == CCM_ADDR_MODE);
        wr_role  = cpu_wr && (cpu_addr == CCM_ADDR_ROLE);
        wr_pri   = cpu_wr && cpu_wide && (cpu_addr == CCM_ADDR_PRI);
        wr_sec   = cpu_wr && cpu_wide && (cpu_addr == CCM_ADDR_SEC);
        mode_new = ((st_r.mode_control_reg & ~cpu_wmask) | (cpu_wdata[7:0] & cpu_wmask))
                   & CCM_MODE_MASK;
        role_new = ((st_r.capture_role_control & ~cpu_wmask) | (cpu_wdata[7:0] & cpu_wmask))
                   & CCM_ROLE_MASK;
    end

    // =========================================================================
    // Capture/compare registers
    // Reverse-edge source captures; otherwise input B edge captures
    assign pri_trig = trig_sel ? a_reverse : b_valid;

    ccm_capcmp_unit u_primary (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .role_capture (pri_role),
        .wr_en        (wr_pri),
        .wr_data      (cpu_wdata),
        .count        (st_r.count_value),
        .running      (running),
        .count_tick   (count_tick),
        .first_tick   (st_r.first_tick),
        .capture_trig (pri_trig),
        .value        (pri_value),
        .match        (pri_match)
    );

    // Secondary trigger never looks at the trigger select bit
    ccm_capcmp_unit u_secondary (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .role_capture (sec_role),
        .wr_en        (wr_sec),
        .wr_data      (cpu_wdata),
        .count        (st_r.count_value),
        .running      (running),
        .count_tick   (count_tick),
        .first_tick   (st_r.first_tick),
        .capture_trig (a_valid),
        .value        (sec_value),
        .match        (sec_match)
    );

    // =========================================================================
    // Counter events
    always_comb begin
        ext_irq   = running && pri_role && trig_sel && b_valid;
        clear_evt = ((run_mode == CCM_EDGE_CLR) && a_valid)
                    || ((run_mode == CCM_MATCH_CLR) && pri_match);
        wrap_set  = running && count_tick && (st_r.count_value == CCM_COUNT_MAX);
    end

    // =========================================================================
    // Next state
    always_comb begin
        st_nxt = st_r;

        // Counter: cleared while stopped, clear events beat the tick
        if (!running) begin
            st_nxt.count_value = CCM_COUNT_ZERO;
        end else if (clear_evt) begin
            st_nxt.count_value = CCM_COUNT_ZERO;
        end else if (count_tick) begin
            st_nxt.count_value = st_r.count_value + CCM_COUNT_ONE;
        end

        // First tick after start is where a zero compare must stay quiet
        if (!running) begin
            st_nxt.first_tick = 1'b1;
        end else if (count_tick) begin
            st_nxt.first_tick = 1'b0;
        end

        // Mode register: stopping a running timer clears the wrap flag,
        // so a flag write of 1 while stopped still sets it; hardware set wins
        if (wr_mode) begin
            st_nxt.mode_control_reg = mode_new;
            if (running && (mode_new[CCM_RUN_HI_BIT:CCM_RUN_LO_BIT] == CCM_STOP)) begin
                st_nxt.mode_control_reg[CCM_WRAP_BIT] = 1'b0;
            end
        end
        if (wrap_set) begin
            st_nxt.mode_control_reg[CCM_WRAP_BIT] = 1'b1;
        end

        if (wr_role) begin
            st_nxt.capture_role_control = role_new;
        end

        // Match and external interrupt requests, one cycle each
        st_nxt.pri_irq = pri_match || ext_irq;
        st_nxt.sec_irq = sec_match;

        // Output toggle; input A edge only counts while running
        if (pri_match || sec_match || (toggle_sel && running && a_valid)) begin
            st_nxt.tout = ~st_r.tout;
        end

        // Read data one cycle after the strobe, zero elsewhere
        st_nxt.rdata = 16'h0000;
        if (cpu_rd) begin
            case (cpu_addr)
                CCM_ADDR_MODE:  st_nxt.rdata = {8'h00, st_r.mode_control_reg};
                CCM_ADDR_ROLE:  st_nxt.rdata = {8'h00, st_r.capture_role_control};
                CCM_ADDR_PRI:   st_nxt.rdata = pri_value;
                CCM_ADDR_SEC:   st_nxt.rdata = sec_value;
                CCM_ADDR_COUNT: st_nxt.rdata = st_r.count_value;
                default:        st_nxt.rdata = 16'h0000;
            endcase
        end
    end

    // =========================================================================
    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r                      <= '0;
            st_r.mode_control_reg     <= CCM_MODE_RST;
            st_r.capture_role_control <= CCM_ROLE_RST;
            st_r.count_value          <= CCM_COUNT_ZERO;
            st_r.first_tick           <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flops
    assign cpu_rdata           = st_r.rdata;
    assign timer_output_pin    = st_r.tout;
    assign primary_match_irq   = st_r.pri_irq;
    assign secondary_match_irq = st_r.sec_irq;

    // =========================================================================
    // Assertions
    default clocking ccm_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_wrap_set;
        running && count_tick && (st_r.count_value == CCM_COUNT_MAX)
            |=> st_r.mode_control_reg[CCM_WRAP_BIT] && (st_r.count_value == 16'h0000);
    endproperty
    a_wrap_set: assert property (p_wrap_set) else $error("wrap flag missed");

    property p_stop_zero;
        !running ##1 !running |-> (st_r.count_value == 16'h0000);
    endproperty
    a_stop_zero: assert property (p_stop_zero) else $error("count not zero stopped");

    property p_pri_irq;
        !pri_role && running && count_tick && !st_r.first_tick
            && (st_r.count_value == pri_value) |=> primary_match_irq;
    endproperty
    a_pri_irq: assert property (p_pri_irq) else $error("primary match irq missed");

    property p_sec_irq;
        !sec_role && running && count_tick && !st_r.first_tick
            && (st_r.count_value == sec_value) |=> secondary_match_irq;
    endproperty
    a_sec_irq: assert property (p_sec_irq) else $error("secondary match irq missed");

    property p_cmp_hold;
        !pri_role && !wr_pri |=> (pri_value == $past(pri_value));
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("compare value changed");

    property p_pri_capture;
        pri_role && running && pri_trig && !wr_pri |=> (pri_value == $past(st_r.count_value));
    endproperty
    a_pri_capture: assert property (p_pri_capture) else $error("primary capture wrong");

    property p_sec_capture;
        sec_role && running && a_valid && !wr_sec |=> (sec_value == $past(st_r.count_value));
    endproperty
    a_sec_capture: assert property (p_sec_capture) else $error("secondary capture wrong");

    property p_zero_quiet;
        running && st_r.first_tick && count_tick && !ext_irq
            |=> !primary_match_irq && !secondary_match_irq;
    endproperty
    a_zero_quiet: assert property (p_zero_quiet) else $error("match right after start");

    property p_edge_clear;
        (run_mode == CCM_EDGE_CLR) && a_valid |=> (st_r.count_value == 16'h0000);
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge clear missed");

    property p_ext_irq;
        ext_irq && !a_reverse && !wr_pri
            |=> primary_match_irq && (pri_value == $past(pri_value));
    endproperty
    a_ext_irq: assert property (p_ext_irq) else $error("external irq missed");

    property p_toggle;
        pri_match || sec_match |=> (timer_output_pin != $past(timer_output_pin));
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not toggle");

    c_wrap:      cover property (wrap_set);
    c_pri_cap:   cover property (pri_role && running && pri_trig);
    c_ext_irq:   cover property (ext_irq);
    c_match_clr: cover property ((run_mode == CCM_MATCH_CLR) && pri_match);
endmodule : ccm_timer_capcmp
